// [bench/nfcmc_mode_chk.sv]
`timescale 1ns/1ps
module nfcmc_mode_chk (
  input wire clk_in,
  input wire resetn_in,
  input wire opc_we_in,
  input wire [7:0] opc_wdata_in,
  input wire [7:0] opc_out,
  input wire power_down_out,
  input wire ready_out,
  input wire wakeup_mode_select_out,
  input wire osc_en_out,
  input wire osc_irq_out,
  input wire mem_access_ok_out,
  input wire tx_on_out,
  input wire rx_on_out,
  input wire meas_diff_in,
  input wire wu_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // -------------------------------------------------------------
  // mode properties
  // -------------------------------------------------------------
  a_reset_pwr_down: assert property ($rose(resetn_in) |-> power_down_out && opc_out == 8'h00)
    else $error("not powered down after reset");
  a_ctrl_write_taken: assert property (opc_we_in |=> opc_out == $past(opc_wdata_in))
    else $error("control write lost");
  a_mode_one_hot: assert property ($onehot({power_down_out, ready_out, wakeup_mode_select_out}))
    else $error("mode not one-hot");
  a_enable_ready: assert property (opc_out[7] |=> ready_out)
    else $error("ready missing");
  a_enable_osc_on: assert property (opc_out[7] |=> osc_en_out)
    else $error("oscillator not enabled");
  a_disable_osc_off: assert property (!opc_out[7] |=> !osc_en_out)
    else $error("oscillator left on");
  a_mem_ready_only: assert property (mem_access_ok_out == $past(opc_out[7]) && !(mem_access_ok_out && power_down_out))
    else $error("memory access does not follow ready");
  a_osc_irq_pulse: assert property (osc_irq_out |-> osc_en_out ##1 !osc_irq_out)
    else $error("oscillator irq wrong");
  a_wake_select: assert property (opc_out == 8'h04 |=> wakeup_mode_select_out)
    else $error("wake mode missing");
  a_tx_rx_bits: assert property ((tx_on_out |-> $past(opc_out[3])) and (rx_on_out |-> $past(opc_out[6])))
    else $error("tx or rx without its bit");
  a_wake_irq_cause: assert property (wu_irq_out |-> $past(meas_diff_in) && $past(wakeup_mode_select_out))
    else $error("wake irq without difference in wake mode");
  c_ready: cover property ($rose(ready_out));
  c_irq: cover property (osc_irq_out);
  c_wake: cover property ($rose(wakeup_mode_select_out));
endmodule

// [bench/nfcmc_osc_model.sv]
`timescale 1ns/1ps
// oscillator settles a fixed time after enable
module nfcmc_osc_model #(parameter int DLY = 1000) (
  input wire clk_in,
  input wire en_in,
  output logic ok_out
);
  int n = 0;
  always @(negedge clk_in) begin
    n = en_in ? n + 1 : 0;
    ok_out <= (n > DLY);
  end
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk_in = 0, resetn_in = 0, opc_we_in = 0, cfg_we_in = 0, sgl = 0, selb = 0, am = 0, meas = 0, txm = 0;
  logic [7:0] wd = 8'h00;
  logic [3:0] dres = 4'h0;
  wire osc_ok, pd, rdy, wum, osc_en, reg_en, antenna_tuning, stab, rx, tx, mem, oirq, wirq, ao_a, ao_b, amq, sq, sbq;
  wire [7:0] opc, sa, sb;
  int err_total = 0, total_checks = 0, cyc = 0, i;
  logic got;
  always #50 clk_in = ~clk_in;
  nfcmc_osc_model u_osc (.clk_in(clk_in), .en_in(osc_en), .ok_out(osc_ok));
  nfcmc_mode_ctrl dut (.clk_in(clk_in), .resetn_in(resetn_in), .opc_we_in(opc_we_in), .opc_wdata_in(wd),
    .cfg_we_in(cfg_we_in), .single_driver_in(sgl), .second_output_select_in(selb),
    .amplitude_vs_onoff_select_in(am), .dres_in(dres), .osc_ok_in(osc_ok), .meas_diff_in(meas), .tx_mod_in(txm),
    .opc_out(opc), .power_down_out(pd), .ready_out(rdy), .wakeup_mode_select_out(wum), .osc_en_out(osc_en),
    .reg_en_out(reg_en), .antenna_tuning_en_out(antenna_tuning), .osc_stable_out(stab), .rx_on_out(rx), .tx_on_out(tx),
    .mem_access_ok_out(mem), .osc_irq_out(oirq), .wu_irq_out(wirq), .wu_meas_out(), .antenna_out_a_out(ao_a),
    .antenna_out_b_out(ao_b), .seg_a_out(sa), .seg_b_out(sb), .am_mode_out(amq),
    .single_q_out(sq), .sel_b_q_out(sbq));
  task results;
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] d);
    @(negedge clk_in) begin opc_we_in = 1; wd = d; end
    @(negedge clk_in) opc_we_in = 0;
    repeat (2) @(negedge clk_in);
  endtask
  task cfg(input logic s, input logic b, input logic a, input logic [3:0] r);
    @(negedge clk_in) begin cfg_we_in = 1; sgl = s; selb = b; am = a; dres = r; end
    @(negedge clk_in) cfg_we_in = 0;
    repeat (2) @(negedge clk_in);
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (3) @(negedge clk_in);
    resetn_in = 1;
    @(negedge clk_in);
    chk({pd, rdy, wum, mem}, 4'h8); chk(opc, 8'h00);
    cfg(1, 0, 0, 4'h4);
    chk({sq, sbq, amq, pd}, 4'h9);
    wr(8'h80);
    chk({rdy, osc_en, reg_en, antenna_tuning, mem}, 5'h1F);
    got = 0;
    for (i = 0; i < 1500 && !got; i++) begin
      @(negedge clk_in);
      if (oirq === 1'b1) got = 1;
    end
    chk({got, stab}, 2'h3);
    wr(8'hC0);
    chk({rx, tx}, 2'h2);
    wr(8'h88);
    chk({rx, tx, ao_a, ao_b}, 4'h6); chk(sa, 8'h0F);
    txm = 1;
    repeat (3) @(negedge clk_in);
    chk(ao_a, 1'b0);
    cfg(1, 0, 1, 4'h4);
    chk({amq, ao_a}, 2'h3);
    txm = 0;
    cfg(1, 1, 0, 4'h0);
    chk({ao_a, ao_b}, 2'h1); chk(sb, 8'hFF);
    wr(8'h00);
    chk({pd, osc_en, reg_en}, 3'h4);
    wr(8'h04);
    chk({wum, pd}, 2'h2);
    meas = 1;
    got = 0;
    for (i = 0; i < 5 && !got; i++) begin
      @(negedge clk_in);
      if (wirq === 1'b1) got = 1;
    end
    chk(got, 1'b1);
    meas = 0;
    wr(8'h84);
    chk({rdy, wum}, 2'h2);
    results();
  end
endmodule
bind nfcmc_mode_ctrl nfcmc_mode_chk u_chk (.clk_in(clk_in), .resetn_in(resetn_in), .opc_we_in(opc_we_in),
  .opc_wdata_in(opc_wdata_in), .opc_out(opc_out), .power_down_out(power_down_out), .ready_out(ready_out),
  .wakeup_mode_select_out(wakeup_mode_select_out), .osc_en_out(osc_en_out), .osc_irq_out(osc_irq_out),
  .mem_access_ok_out(mem_access_ok_out), .tx_on_out(tx_on_out), .rx_on_out(rx_on_out),
  .meas_diff_in(meas_diff_in), .wu_irq_out(wu_irq_out));

// [inc/nfcmc_defines.vh]
`ifndef NFCMC_DEFINES_VH
`define NFCMC_DEFINES_VH

// ---------------------------------------------------------------
// operation control fields
// ---------------------------------------------------------------
`define NFCMC_OPC_W 8
`define NFCMC_OPC_RST 8'h00
`define NFCMC_OPC_EN 7
`define NFCMC_OPC_RX 6
`define NFCMC_OPC_TX 3
`define NFCMC_OPC_WU 2

// ---------------------------------------------------------------
// driver configuration
// ---------------------------------------------------------------
`define NFCMC_SEG_N 8
`define NFCMC_DRES_W 4
`define NFCMC_DRES_RST 4'h0
`define NFCMC_DRES_ONE 4'h1

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define NFCMC_CLK_HZ 10000000
`define NFCMC_OSC_STABLE_US 100
`define NFCMC_OSC_CYC ((`NFCMC_OSC_STABLE_US * (`NFCMC_CLK_HZ / 1000000)))
`define NFCMC_CNT_W 16
`define NFCMC_WU_PERIOD_MS 100
`define NFCMC_WU_CYC ((`NFCMC_WU_PERIOD_MS * (`NFCMC_CLK_HZ / 1000)))
`define NFCMC_WUCNT_W 24

`endif

// [logic/nfcmc_drv_seg.v]
`timescale 1ns/1ps
`include "nfcmc_defines.vh"

module nfcmc_drv_seg (
  input wire clk_in,
  input wire resetn_in,
  input wire active_in,
  input wire [`NFCMC_DRES_W-1:0] dres_in,
  output reg [`NFCMC_SEG_N-1:0] seg_out
);

  // -------------------------------------------------------------
  // segment enables
  // -------------------------------------------------------------
  genvar g;
  wire [`NFCMC_SEG_N-1:0] seg_d;
  generate
    for (g = 0; g < `NFCMC_SEG_N; g = g + 1) begin : g_seg
      assign seg_d[g] = active_in & ({1'b0, dres_in} < (`NFCMC_SEG_N - g));
    end
  endgenerate

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      seg_out <= {`NFCMC_SEG_N{1'b0}};
    end else begin
      seg_out <= seg_d;
    end
  end

endmodule

// [logic/nfcmc_mode_ctrl.v]
`timescale 1ns/1ps
`include "nfcmc_defines.vh"

// Notes on behaviour
// - power-up: power-down, registers at defaults
// - control register zero means power-down
// - configuration writable while powered down
// - target ram and fifo blocked when down
// - enable bit starts oscillator, regulators, tuning
// - interrupt once oscillator is stable
// - receiver and transmitter enabled separately
// - wake-up bit alone selects wake-up mode
// - wake-up interrupt on measurement difference
// - single-driver bit uses one driver
// - output select swaps antenna circuits
// - eight weighted segments, msb ones removable
// - four-bit resistance, reset minimum resistance
// - mode bit picks am or on-off keying
module nfcmc_mode_ctrl (
  input wire clk_in,
  input wire resetn_in,
  input wire opc_we_in,
  input wire [`NFCMC_OPC_W-1:0] opc_wdata_in,
  input wire cfg_we_in,
  input wire single_driver_in,
  input wire second_output_select_in,
  input wire amplitude_vs_onoff_select_in,
  input wire [`NFCMC_DRES_W-1:0] dres_in,
  input wire osc_ok_in,
  input wire meas_diff_in,
  input wire tx_mod_in,
  output reg [`NFCMC_OPC_W-1:0] opc_out,
  output wire power_down_out,
  output wire ready_out,
  output wire wakeup_mode_select_out,
  output reg osc_en_out,
  output reg reg_en_out,
  output reg antenna_tuning_en_out,
  output reg osc_stable_out,
  output reg rx_on_out,
  output reg tx_on_out,
  output wire mem_access_ok_out,
  output reg osc_irq_out,
  output reg wu_irq_out,
  output reg wu_meas_out,
  output reg antenna_out_a_out,
  output reg antenna_out_b_out,
  output wire [`NFCMC_SEG_N-1:0] seg_a_out,
  output wire [`NFCMC_SEG_N-1:0] seg_b_out,
  output reg am_mode_out,
  output reg single_q_out,
  output reg sel_b_q_out
);

  // -------------------------------------------------------------
  // states
  // -------------------------------------------------------------
  localparam ST_DOWN = 3'b001;
  localparam ST_READY = 3'b010;
  localparam ST_WAKE = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`NFCMC_CNT_W-1:0] osc_cnt_q;
  reg [`NFCMC_WUCNT_W-1:0] wu_cnt_q;
  reg [`NFCMC_DRES_W-1:0] dres_q;
  reg osc_done_q;

  wire en_bit = opc_out[`NFCMC_OPC_EN];
  wire wu_bit = opc_out[`NFCMC_OPC_WU];
  wire wu_only = (opc_out == (`NFCMC_OPC_RST | (8'h01 << `NFCMC_OPC_WU)));

  // -------------------------------------------------------------
  // mode decode
  // -------------------------------------------------------------
  always @* begin
    state_d = ST_DOWN;
    case (1'b1)
      en_bit: state_d = ST_READY;
      wu_only: state_d = ST_WAKE;
      default: state_d = ST_DOWN;
    endcase
  end

  assign power_down_out = state_q[0];
  assign ready_out = state_q[1];
  assign wakeup_mode_select_out = state_q[2];
  assign mem_access_ok_out = state_q[1];

  // -------------------------------------------------------------
  // control and configuration registers
  // -------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      opc_out <= `NFCMC_OPC_RST;
      state_q <= ST_DOWN;
      single_q_out <= 1'b0;
      sel_b_q_out <= 1'b0;
      am_mode_out <= 1'b0;
      dres_q <= `NFCMC_DRES_RST;
    end else begin
      state_q <= state_d;
      if (opc_we_in) begin
        opc_out <= opc_wdata_in;
      end
      if (cfg_we_in) begin
        single_q_out <= single_driver_in;
        sel_b_q_out <= second_output_select_in;
        am_mode_out <= amplitude_vs_onoff_select_in;
        dres_q <= dres_in;
      end
    end
  end

  // -------------------------------------------------------------
  // oscillator start-up and interrupts
  // -------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      osc_en_out <= 1'b0;
      reg_en_out <= 1'b0;
      antenna_tuning_en_out <= 1'b0;
      osc_cnt_q <= {`NFCMC_CNT_W{1'b0}};
      osc_stable_out <= 1'b0;
      osc_done_q <= 1'b0;
      osc_irq_out <= 1'b0;
      rx_on_out <= 1'b0;
      tx_on_out <= 1'b0;
    end else begin
      osc_en_out <= en_bit;
      reg_en_out <= en_bit;
      antenna_tuning_en_out <= en_bit;
      osc_irq_out <= 1'b0;
      if (!en_bit) begin
        osc_cnt_q <= {`NFCMC_CNT_W{1'b0}};
        osc_stable_out <= 1'b0;
        osc_done_q <= 1'b0;
      end else if (!osc_done_q) begin
        if (osc_cnt_q < `NFCMC_OSC_CYC - 1) begin
          osc_cnt_q <= osc_cnt_q + 16'h0001;
        end else if (osc_ok_in) begin
          osc_stable_out <= 1'b1;
          osc_done_q <= 1'b1;
          osc_irq_out <= 1'b1;
        end
      end
      rx_on_out <= osc_stable_out & opc_out[`NFCMC_OPC_RX];
      tx_on_out <= osc_stable_out & opc_out[`NFCMC_OPC_TX];
    end
  end

  // -------------------------------------------------------------
  // wake-up timer
  // -------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      wu_cnt_q <= {`NFCMC_WUCNT_W{1'b0}};
      wu_meas_out <= 1'b0;
      wu_irq_out <= 1'b0;
    end else begin
      wu_meas_out <= 1'b0;
      wu_irq_out <= 1'b0;
      if (!state_q[2]) begin
        wu_cnt_q <= {`NFCMC_WUCNT_W{1'b0}};
      end else if (wu_cnt_q == `NFCMC_WU_CYC - 1) begin
        wu_cnt_q <= {`NFCMC_WUCNT_W{1'b0}};
        wu_meas_out <= 1'b1;
      end else begin
        wu_cnt_q <= wu_cnt_q + 24'h000001;
      end
      if (state_q[2] && meas_diff_in) begin
        wu_irq_out <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // driver output selection
  // -------------------------------------------------------------
  wire drv_a_on = tx_on_out & (~single_q_out | ~sel_b_q_out);
  wire drv_b_on = tx_on_out & (~single_q_out | sel_b_q_out);

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      antenna_out_a_out <= 1'b0;
      antenna_out_b_out <= 1'b0;
    end else begin
      // ook stops carrier, am keeps it
      antenna_out_a_out <= drv_a_on & (am_mode_out | ~tx_mod_in);
      antenna_out_b_out <= drv_b_on & (am_mode_out | ~tx_mod_in);
    end
  end

  nfcmc_drv_seg u_seg_a (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .active_in(drv_a_on),
    .dres_in(dres_q),
    .seg_out(seg_a_out)
  );

  nfcmc_drv_seg u_seg_b (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .active_in(drv_b_on),
    .dres_in(dres_q),
    .seg_out(seg_b_out)
  );

endmodule
